// *** src/tlb_entry_write.sv ***
// TLB entry write path: staging registers, slot choice, commit and faults
//
// What this block does
// (RL1) Random write picks its slot from the random register, not the index.
// (RL2) Indexed write picks its slot from the index register.
// (RL3) Entry takes staging high, both lows and page mask sampled at execution.
// (RL4) Virtual page pair bits under set mask bits may be zeroed; control bit picks.
// (RL5) Both frame numbers may have masked bits zeroed; same control bit picks.
// (RL6) Stored global bit is AND of even and odd staging global bits.
// (RL7) Duplicate match found on write raises machine check.
// (RL8) Duplicate matches reported only on writes, never on read-back.
// (RL9) Coprocessor zero disabled: raise unusable fault, leave the TLB untouched.
// (RL10) Software keeps the index below the entry count before indexed writes.
// (RL11) Mask, region, identifier copied; cache, dirty, valid per page from its low.
`timescale 1ns/1ps
`include "tlb_write_regs.svh"

module tlb_entry_write (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tlb_write_indexed_op,
  input wire logic tlb_write_random_op,
  input wire logic cp0_usable,
  output logic tlb_write_busy,
  output logic tlb_write_done,
  output logic machine_check,
  output logic cop_unusable,
  output logic irq
);
  import tlb_write_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  tlb_write_pkg::state_t state_reg;
  tlb_write_pkg::state_t state_next;
  logic [31:0] entry_high_staging;
  logic [31:0] even_page_low_staging;
  logic [31:0] odd_page_low_staging;
  logic [31:0] page_size_mask;
  logic [`IDX_W-1:0] index_reg;
  logic [`IDX_W-1:0] random_reg;
  logic [`IDX_W-1:0] rd_sel_reg;
  logic [1:0] ctrl_reg;
  logic [`EV_W-1:0] status_reg;
  logic [`EV_W-1:0] irq_mask_reg;
  logic [`EV_W-1:0] events;
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] rd_mux;
  logic rd_err;
  logic cmd_idx;
  logic cmd_rnd;
  logic want_idx;
  logic want_rnd;
  logic accept;
  logic commit_ok;
  logic commit_bad;
  logic [`IDX_W-1:0] lat_slot;
  logic [`VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] lat_virtual_page_pair_number;
  logic [`ADDRESS_SPACE_IDENTIFIER_W-1:0] lat_address_space_identifier;
  logic [`REGION_W-1:0] lat_region;
  logic [`MASK_W-1:0] lat_mask;
  logic lat_global;
  logic [`PFN_W-1:0] lat_even_physical_frame;
  logic [`PFN_W-1:0] lat_odd_physical_frame;
  logic [`CATTR_W+1:0] lat_cdv0;
  logic [`CATTR_W+1:0] lat_cdv1;
  logic [`MASK_W-1:0] st_mask;
  logic [`VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] st_virtual_page_pair_number;
  logic [`PFN_W-1:0] st_even_physical_frame;
  logic [`PFN_W-1:0] st_odd_physical_frame;
  logic dup_hit;
  logic [`VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] rb_virtual_page_pair_number;
  logic [`ADDRESS_SPACE_IDENTIFIER_W-1:0] rb_address_space_identifier;
  logic [`REGION_W-1:0] rb_region;
  logic [`MASK_W-1:0] rb_mask;
  logic rb_global;
  logic [`PFN_W-1:0] rb_even_physical_frame;
  logic [`PFN_W-1:0] rb_odd_physical_frame;
  logic [`CATTR_W+1:0] rb_cdv0;
  logic [`CATTR_W+1:0] rb_cdv1;

  // ****************************************
  // APB decode
  // ****************************************
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable && pready;
  assign apb_wr = apb_access && pwrite;
  assign apb_rd = apb_access && !pwrite;
  assign cmd_idx = apb_wr && (paddr == `OFS_CMD) && pwdata[`CMD_INDEXED];
  assign cmd_rnd = apb_wr && (paddr == `OFS_CMD) && pwdata[`CMD_RANDOM];

  // Zero wait state: data and pready are loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      prdata <= apb_setup && !pwrite ? rd_mux : 32'h0000_0000;
      pslverr <= apb_setup && rd_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_high_staging <= 32'h0000_0000;
      even_page_low_staging <= 32'h0000_0000;
      odd_page_low_staging <= 32'h0000_0000;
      page_size_mask <= 32'h0000_0000;
      index_reg <= '0;
      rd_sel_reg <= '0;
      ctrl_reg <= `CTRL_RESET;
      irq_mask_reg <= `IRQ_MASK_RESET;
    end else if (apb_wr) begin
      if (paddr == `OFS_ENTRY_HIGH) begin
        entry_high_staging <= pwdata;
      end else if (paddr == `OFS_EVEN_LOW) begin
        even_page_low_staging <= pwdata;
      end else if (paddr == `OFS_ODD_LOW) begin
        odd_page_low_staging <= pwdata;
      end else if (paddr == `OFS_PAGE_MASK) begin
        page_size_mask <= pwdata;
      end else if (paddr == `OFS_INDEX) begin
        index_reg <= pwdata[`IDX_W-1:0];
      end else if (paddr == `OFS_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end else if (paddr == `OFS_IRQ_MASK) begin
        irq_mask_reg <= pwdata[`EV_W-1:0];
      end else if (paddr == `OFS_RD_SEL) begin
        rd_sel_reg <= pwdata[`IDX_W-1:0];
      end
    end
  end

  // Read-back never runs the duplicate check (RL8)
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == `OFS_ENTRY_HIGH) begin
      rd_mux = entry_high_staging;
    end else if (paddr == `OFS_EVEN_LOW) begin
      rd_mux = even_page_low_staging;
    end else if (paddr == `OFS_ODD_LOW) begin
      rd_mux = odd_page_low_staging;
    end else if (paddr == `OFS_PAGE_MASK) begin
      rd_mux = page_size_mask;
    end else if (paddr == `OFS_INDEX) begin
      rd_mux[`IDX_W-1:0] = index_reg;
    end else if (paddr == `OFS_RANDOM) begin
      rd_mux[`IDX_W-1:0] = random_reg;
    end else if (paddr == `OFS_CTRL) begin
      rd_mux[1:0] = ctrl_reg;
    end else if (paddr == `OFS_CMD) begin
      rd_mux[0] = tlb_write_busy;
    end else if (paddr == `OFS_STATUS) begin
      rd_mux[`EV_W-1:0] = status_reg;
    end else if (paddr == `OFS_IRQ_MASK) begin
      rd_mux[`EV_W-1:0] = irq_mask_reg;
    end else if (paddr == `OFS_RD_SEL) begin
      rd_mux[`IDX_W-1:0] = rd_sel_reg;
    end else if (paddr == `OFS_RD_HIGH) begin
      rd_mux[`EHI_VIRTUAL_PAGE_PAIR_NUMBER_HI:`EHI_VIRTUAL_PAGE_PAIR_NUMBER_LO] = rb_virtual_page_pair_number;
      rd_mux[`EHI_REGION_HI:`EHI_REGION_LO] = rb_region;
      rd_mux[`EHI_ADDRESS_SPACE_IDENTIFIER_HI:`EHI_ADDRESS_SPACE_IDENTIFIER_LO] = rb_address_space_identifier;
    end else if (paddr == `OFS_RD_EVEN) begin
      rd_mux[`ELO_PFN_HI:`ELO_PFN_LO] = rb_even_physical_frame;
      rd_mux[`ELO_C_HI:`ELO_V] = rb_cdv0;
      rd_mux[`ELO_G] = rb_global;
    end else if (paddr == `OFS_RD_ODD) begin
      rd_mux[`ELO_PFN_HI:`ELO_PFN_LO] = rb_odd_physical_frame;
      rd_mux[`ELO_C_HI:`ELO_V] = rb_cdv1;
      rd_mux[`ELO_G] = rb_global;
    end else if (paddr == `OFS_RD_MASK) begin
      rd_mux[`PM_MASK_HI:`PM_MASK_LO] = rb_mask;
    end else begin
      rd_err = 1'b1;
    end
  end

  // ****************************************
  // Random replacement counter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      random_reg <= `RANDOM_RESET;
    end else if (random_reg == '0) begin
      random_reg <= `IDX_W'(`TLB_ENTRIES - 1);
    end else begin
      random_reg <= random_reg - 1'b1;
    end
  end

  // ****************************************
  // Staging snapshot with optional zeroing
  // ****************************************
  assign st_mask = page_size_mask[`PM_MASK_HI:`PM_MASK_LO];
  always_comb begin
    st_virtual_page_pair_number = entry_high_staging[`EHI_VIRTUAL_PAGE_PAIR_NUMBER_HI:`EHI_VIRTUAL_PAGE_PAIR_NUMBER_LO];
    st_even_physical_frame = even_page_low_staging[`ELO_PFN_HI:`ELO_PFN_LO];
    st_odd_physical_frame = odd_page_low_staging[`ELO_PFN_HI:`ELO_PFN_LO];
    if (ctrl_reg[`CTRL_ZERO_MASKED]) begin
      st_virtual_page_pair_number = st_virtual_page_pair_number & ~{{(`VIRTUAL_PAGE_PAIR_NUMBER_W-`MASK_W){1'b0}}, st_mask}; // RL4
      st_even_physical_frame = st_even_physical_frame & ~{{(`PFN_W-`MASK_W){1'b0}}, st_mask}; // RL5
      st_odd_physical_frame = st_odd_physical_frame & ~{{(`PFN_W-`MASK_W){1'b0}}, st_mask}; // RL5
    end
  end

  // Pin and command requests merge; indexed wins if both arrive together
  assign want_idx = tlb_write_indexed_op || cmd_idx;
  assign want_rnd = tlb_write_random_op || cmd_rnd;
  assign accept = (state_reg == ST_IDLE) && (want_idx || want_rnd) && cp0_usable; // RL9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_slot <= '0;
      lat_virtual_page_pair_number <= '0;
      lat_address_space_identifier <= '0;
      lat_region <= '0;
      lat_mask <= '0;
      lat_global <= 1'b0;
      lat_even_physical_frame <= '0;
      lat_odd_physical_frame <= '0;
      lat_cdv0 <= '0;
      lat_cdv1 <= '0;
    end else if (accept) begin
      lat_slot <= want_idx ? index_reg : random_reg; // RL1 RL2 RL10
      lat_virtual_page_pair_number <= st_virtual_page_pair_number; // RL3
      lat_address_space_identifier <= entry_high_staging[`EHI_ADDRESS_SPACE_IDENTIFIER_HI:`EHI_ADDRESS_SPACE_IDENTIFIER_LO]; // RL11
      lat_region <= entry_high_staging[`EHI_REGION_HI:`EHI_REGION_LO]; // RL11
      lat_mask <= st_mask; // RL11
      lat_global <= even_page_low_staging[`ELO_G] && odd_page_low_staging[`ELO_G]; // RL6
      lat_even_physical_frame <= st_even_physical_frame;
      lat_odd_physical_frame <= st_odd_physical_frame;
      lat_cdv0 <= even_page_low_staging[`ELO_C_HI:`ELO_V]; // RL11
      lat_cdv1 <= odd_page_low_staging[`ELO_C_HI:`ELO_V]; // RL11
    end
  end

  // ****************************************
  // Commit sequence
  // ****************************************
  assign commit_bad = (state_reg == ST_COMMIT) && ctrl_reg[`CTRL_DUP_CHECK] && dup_hit; // RL7 RL8
  assign commit_ok = (state_reg == ST_COMMIT) && !commit_bad;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      tlb_write_busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      tlb_write_busy <= state_next == ST_COMMIT;
    end
  end

  assign events[`EV_DONE] = commit_ok;
  assign events[`EV_MCHECK] = commit_bad; // RL7
  assign events[`EV_UNUSABLE] = (state_reg == ST_IDLE) && (want_idx || want_rnd) && !cp0_usable; // RL9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tlb_write_done <= 1'b0;
      machine_check <= 1'b0;
      cop_unusable <= 1'b0;
    end else begin
      tlb_write_done <= events[`EV_DONE];
      machine_check <= events[`EV_MCHECK];
      cop_unusable <= events[`EV_UNUSABLE];
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  // Only bits already shown in prdata clear; later events stay set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else if (apb_rd && (paddr == `OFS_STATUS)) begin
      status_reg <= (status_reg & ~prdata[`EV_W-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & irq_mask_reg);
    end
  end

  // ****************************************
  // Entry array
  // ****************************************
  tlb_entry_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(commit_ok), // RL9
    .wr_slot(lat_slot),
    .wr_virtual_page_pair_number(lat_virtual_page_pair_number),
    .wr_address_space_identifier(lat_address_space_identifier),
    .wr_region(lat_region),
    .wr_mask(lat_mask),
    .wr_global(lat_global),
    .wr_even_physical_frame(lat_even_physical_frame),
    .wr_cdv0(lat_cdv0),
    .wr_odd_physical_frame(lat_odd_physical_frame),
    .wr_cdv1(lat_cdv1),
    .rd_slot(rd_sel_reg),
    .rd_virtual_page_pair_number(rb_virtual_page_pair_number),
    .rd_address_space_identifier(rb_address_space_identifier),
    .rd_region(rb_region),
    .rd_mask(rb_mask),
    .rd_global(rb_global),
    .rd_even_physical_frame(rb_even_physical_frame),
    .rd_cdv0(rb_cdv0),
    .rd_odd_physical_frame(rb_odd_physical_frame),
    .rd_cdv1(rb_cdv1),
    .dup_hit(dup_hit)
  );

endmodule

// *** src/tlb_write_regs.svh ***
// Offsets, field positions, widths and reset values of the TLB write block
`ifndef TLB_WRITE_REGS_SVH
`define TLB_WRITE_REGS_SVH

// ****************************************
// Geometry
// ****************************************
`define TLB_ENTRIES 16
`define IDX_W 4
`define VIRTUAL_PAGE_PAIR_NUMBER_W 19
`define ADDRESS_SPACE_IDENTIFIER_W 8
`define REGION_W 2
`define MASK_W 16
`define PFN_W 20
`define CATTR_W 3

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_ENTRY_HIGH 8'h00
`define OFS_EVEN_LOW 8'h04
`define OFS_ODD_LOW 8'h08
`define OFS_PAGE_MASK 8'h0C
`define OFS_INDEX 8'h10
`define OFS_RANDOM 8'h14
`define OFS_CTRL 8'h18
`define OFS_CMD 8'h1C
`define OFS_STATUS 8'h20
`define OFS_IRQ_MASK 8'h24
`define OFS_RD_SEL 8'h28
`define OFS_RD_HIGH 8'h2C
`define OFS_RD_EVEN 8'h30
`define OFS_RD_ODD 8'h34
`define OFS_RD_MASK 8'h38

// ****************************************
// Field positions
// ****************************************
`define EHI_VIRTUAL_PAGE_PAIR_NUMBER_HI 31
`define EHI_VIRTUAL_PAGE_PAIR_NUMBER_LO 13
`define EHI_REGION_HI 9
`define EHI_REGION_LO 8
`define EHI_ADDRESS_SPACE_IDENTIFIER_HI 7
`define EHI_ADDRESS_SPACE_IDENTIFIER_LO 0
`define ELO_PFN_HI 25
`define ELO_PFN_LO 6
`define ELO_C_HI 5
`define ELO_C_LO 3
`define ELO_D 2
`define ELO_V 1
`define ELO_G 0
`define PM_MASK_HI 28
`define PM_MASK_LO 13
`define CTRL_ZERO_MASKED 0
`define CTRL_DUP_CHECK 1
`define CMD_INDEXED 0
`define CMD_RANDOM 1
`define EV_DONE 0
`define EV_MCHECK 1
`define EV_UNUSABLE 2
`define EV_W 3

// ****************************************
// Reset values
// ****************************************
`define CTRL_RESET 2'h3
`define IRQ_MASK_RESET 3'h0
`define RANDOM_RESET 4'hF

`endif

// *** src/tlb_write_pkg.sv ***
// Types shared by the TLB write block
package tlb_write_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_COMMIT = 2'b10
  } state_t;

endpackage

// *** src/tlb_entry_store.sv ***
// TLB entry array with write port, read-back port and duplicate match check
`timescale 1ns/1ps
`include "tlb_write_regs.svh"

module tlb_entry_store (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [`IDX_W-1:0] wr_slot,
  input wire logic [`VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] wr_virtual_page_pair_number,
  input wire logic [`ADDRESS_SPACE_IDENTIFIER_W-1:0] wr_address_space_identifier,
  input wire logic [`REGION_W-1:0] wr_region,
  input wire logic [`MASK_W-1:0] wr_mask,
  input wire logic wr_global,
  input wire logic [`PFN_W-1:0] wr_even_physical_frame,
  input wire logic [`CATTR_W+1:0] wr_cdv0,
  input wire logic [`PFN_W-1:0] wr_odd_physical_frame,
  input wire logic [`CATTR_W+1:0] wr_cdv1,
  input wire logic [`IDX_W-1:0] rd_slot,
  output logic [`VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] rd_virtual_page_pair_number,
  output logic [`ADDRESS_SPACE_IDENTIFIER_W-1:0] rd_address_space_identifier,
  output logic [`REGION_W-1:0] rd_region,
  output logic [`MASK_W-1:0] rd_mask,
  output logic rd_global,
  output logic [`PFN_W-1:0] rd_even_physical_frame,
  output logic [`CATTR_W+1:0] rd_cdv0,
  output logic [`PFN_W-1:0] rd_odd_physical_frame,
  output logic [`CATTR_W+1:0] rd_cdv1,
  output logic dup_hit
);
  logic [`VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] virtual_page_pair_number_a [`TLB_ENTRIES];
  logic [`ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier_a [`TLB_ENTRIES];
  logic [`REGION_W-1:0] region_a [`TLB_ENTRIES];
  logic [`MASK_W-1:0] mask_a [`TLB_ENTRIES];
  logic [`PFN_W-1:0] even_physical_frame_a [`TLB_ENTRIES];
  logic [`PFN_W-1:0] odd_physical_frame_a [`TLB_ENTRIES];
  logic [`CATTR_W+1:0] cdv0_a [`TLB_ENTRIES];
  logic [`CATTR_W+1:0] cdv1_a [`TLB_ENTRIES];
  logic [`TLB_ENTRIES-1:0] global_reg;
  logic [`TLB_ENTRIES-1:0] loaded_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `TLB_ENTRIES; i++) begin
        virtual_page_pair_number_a[i] <= '0;
        address_space_identifier_a[i] <= '0;
        region_a[i] <= '0;
        mask_a[i] <= '0;
        even_physical_frame_a[i] <= '0;
        odd_physical_frame_a[i] <= '0;
        cdv0_a[i] <= '0;
        cdv1_a[i] <= '0;
      end
      global_reg <= '0;
      loaded_reg <= '0;
    end else if (wr_en) begin
      virtual_page_pair_number_a[wr_slot] <= wr_virtual_page_pair_number;
      address_space_identifier_a[wr_slot] <= wr_address_space_identifier;
      region_a[wr_slot] <= wr_region;
      mask_a[wr_slot] <= wr_mask;
      even_physical_frame_a[wr_slot] <= wr_even_physical_frame;
      odd_physical_frame_a[wr_slot] <= wr_odd_physical_frame;
      cdv0_a[wr_slot] <= wr_cdv0;
      cdv1_a[wr_slot] <= wr_cdv1;
      global_reg[wr_slot] <= wr_global;
      loaded_reg[wr_slot] <= 1'b1;
    end
  end

  // Only loaded entries other than the target slot count; the target is replaced
  always_comb begin
    logic [`VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] m;
    dup_hit = 1'b0;
    m = '0;
    for (int j = 0; j < `TLB_ENTRIES; j++) begin
      m = {{(`VIRTUAL_PAGE_PAIR_NUMBER_W-`MASK_W){1'b0}}, mask_a[j]};
      if (loaded_reg[j] && (j[`IDX_W-1:0] != wr_slot) &&
          ((virtual_page_pair_number_a[j] & ~m) == (wr_virtual_page_pair_number & ~m)) && (region_a[j] == wr_region) &&
          (global_reg[j] || (address_space_identifier_a[j] == wr_address_space_identifier))) begin
        dup_hit = 1'b1;
      end
    end
  end

  assign rd_virtual_page_pair_number = virtual_page_pair_number_a[rd_slot];
  assign rd_address_space_identifier = address_space_identifier_a[rd_slot];
  assign rd_region = region_a[rd_slot];
  assign rd_mask = mask_a[rd_slot];
  assign rd_global = global_reg[rd_slot];
  assign rd_even_physical_frame = even_physical_frame_a[rd_slot];
  assign rd_cdv0 = cdv0_a[rd_slot];
  assign rd_odd_physical_frame = odd_physical_frame_a[rd_slot];
  assign rd_cdv1 = cdv1_a[rd_slot];

endmodule

// *** tb/tlb_entry_write_props.sv ***
// Concurrent checks on the ports of the TLB entry write block
`timescale 1ns/1ps
module tlb_entry_write_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tlb_write_indexed_op,
  input wire logic tlb_write_random_op,
  input wire logic cp0_usable,
  input wire logic tlb_write_busy,
  input wire logic tlb_write_done,
  input wire logic machine_check,
  input wire logic cop_unusable,
  input wire logic irq
);
  logic req;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Requests while busy are dropped, so only idle ones count
  assign req = (tlb_write_indexed_op | tlb_write_random_op) & ~tlb_write_busy;
  a_take_busy: assert property (req && cp0_usable |=> tlb_write_busy)
    else $error("accepted write did not go busy");
  a_busy_outcome: assert property (tlb_write_busy |=> (tlb_write_done ^ machine_check) && !tlb_write_busy)
    else $error("commit cycle without single outcome");
  a_refuse_fault: assert property (req && !cp0_usable |=> cop_unusable && !tlb_write_busy)
    else $error("disabled access not refused");
  a_fault_alone: assert property (cop_unusable |-> !tlb_write_done && !machine_check)
    else $error("refused write still committed");
  a_check_write: assert property (machine_check |-> $past(tlb_write_busy))
    else $error("machine check outside a write");
  a_done_write: assert property (tlb_write_done |-> $past(tlb_write_busy) && !machine_check)
    else $error("done without a commit cycle");
  a_ready_setup: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_idle_data: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access phase");
  cover property (machine_check);
  cover property (cop_unusable);
  cover property (tlb_write_done ##1 irq);
endmodule

// *** tb/core_issue_model.sv ***
// Core pipeline model issuing privileged TLB write pulses
`timescale 1ns/1ps
module core_issue_model (
  input wire logic pclk,
  output logic tlb_write_indexed_op,
  output logic tlb_write_random_op,
  output logic cp0_usable
);
  initial begin
    tlb_write_indexed_op = 1'b0;
    tlb_write_random_op = 1'b0;
    cp0_usable = 1'b1;
  end
  // One-cycle pulse; index is 4 bits so it stays below the entry count
  task issue(input logic rnd, input logic usable);
    tlb_write_indexed_op <= !rnd;
    tlb_write_random_op <= rnd;
    cp0_usable <= usable;
    @(posedge pclk);
    tlb_write_indexed_op <= 1'b0;
    tlb_write_random_op <= 1'b0;
    cp0_usable <= 1'b1;
  endtask
endmodule

// *** tb/tlb_entry_write_tb.sv ***
// Self-checking bench of the TLB entry write block
`timescale 1ns/1ps
`include "tlb_write_regs.svh"
module tlb_entry_write_tb;
  import tlb_write_pkg::*;
  localparam logic [31:0] HA = {19'h12345, 3'h0, 2'h1, 8'h3C};
  localparam logic [31:0] HB = {19'h0ABCD, 3'h0, 2'h1, 8'h3C};
  localparam logic [31:0] HC = {19'h07777, 3'h0, 2'h2, 8'h11};
  localparam logic [31:0] L0 = {6'h0, 20'hABCDE, 3'h3, 3'b111};
  localparam logic [31:0] L1 = {6'h0, 20'h13579, 3'h5, 3'b010};
  localparam logic [31:0] PM = {3'h0, 16'h0003, 13'h0};
  localparam logic [31:0] PF = ~(PM >> 7);
  logic pclk, presetn, psel, penable, pwrite, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] r, d;
  logic [31:0] prdata;
  logic pready, pslverr, iop, rop, usable, busy, done, mchk, unus, irq;
  int n_mismatch, n_tests, cyc, hit, cnt;
  core_issue_model core_u (.pclk(pclk), .tlb_write_indexed_op(iop), .tlb_write_random_op(rop), .cp0_usable(usable));
  tlb_entry_write dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tlb_write_indexed_op(iop), .tlb_write_random_op(rop), .cp0_usable(usable), .tlb_write_busy(busy),
    .tlb_write_done(done), .machine_check(mchk), .cop_unusable(unus), .irq(irq));
  // ****************************************
  // Tasks
  // ****************************************
  task tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Idle cycle after each transfer keeps every strobe to one assignment per step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_evt(input logic [2:0] e);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ({unus, mchk, done} === 3'b000 && k < 8);
    chk({29'h0, unus, mchk, done}, {29'h0, e});
  endtask
  task rb_high(input logic [3:0] s);
    apb(1'b1, `OFS_RD_SEL, {28'h0, s});
    apb(1'b0, `OFS_RD_HIGH, 32'h0);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, `OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, `OFS_ENTRY_HIGH, HA);
    apb(1'b1, `OFS_EVEN_LOW, L0);
    apb(1'b1, `OFS_ODD_LOW, L1);
    apb(1'b1, `OFS_PAGE_MASK, PM);
    apb(1'b1, `OFS_INDEX, 32'h5);
    core_u.issue(1'b0, 1'b1);
    wait_evt(3'b001);
    rb_high(4'h5);
    chk(rd, HA & ~PM);
    apb(1'b0, `OFS_RD_EVEN, 32'h0);
    chk(rd, L0 & PF & ~32'h1);
    apb(1'b0, `OFS_RD_ODD, 32'h0);
    chk(rd, L1 & PF);
    apb(1'b0, `OFS_RD_MASK, 32'h0);
    chk(rd, PM);
    // Random slot must trail the random register, far from the index
    apb(1'b1, `OFS_ENTRY_HIGH, HB);
    apb(1'b0, `OFS_RANDOM, 32'h0);
    r = rd[3:0];
    apb(1'b1, `OFS_INDEX, {28'h0, r + 4'h4});
    core_u.issue(1'b1, 1'b1);
    wait_evt(3'b001);
    cnt = 0;
    for (int s = 0; s < 16; s++) begin
      rb_high(s[3:0]);
      if (rd === (HB & ~PM)) begin
        cnt++;
        hit = s;
      end
    end
    d = r - hit[3:0];
    chk(cnt, 1);
    chk({31'h0, d >= 4'h1 && d <= 4'h9}, 32'h1);
    apb(1'b1, `OFS_ENTRY_HIGH, HA);
    apb(1'b1, `OFS_INDEX, 32'h6);
    core_u.issue(1'b0, 1'b1);
    wait_evt(3'b010);
    rb_high(4'h6);
    chk({31'h0, rd === (HA & ~PM)}, 32'h0);
    apb(1'b1, `OFS_ENTRY_HIGH, HC);
    apb(1'b1, `OFS_INDEX, 32'h9);
    core_u.issue(1'b0, 1'b0);
    wait_evt(3'b100);
    rb_high(4'h9);
    chk({31'h0, rd === (HC & ~PM)}, 32'h0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    // Zeroing off, write through the command register, done interrupt
    apb(1'b1, `OFS_CTRL, 32'h2);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    apb(1'b1, `OFS_ENTRY_HIGH, HC);
    apb(1'b1, `OFS_INDEX, 32'hA);
    apb(1'b1, `OFS_ODD_LOW, L1 | 32'h1);
    apb(1'b1, `OFS_CMD, 32'h1);
    wait_evt(3'b001);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rb_high(4'hA);
    chk(rd, HC);
    apb(1'b0, `OFS_RD_EVEN, 32'h0);
    chk(rd, L0);
    apb(1'b0, `OFS_RD_ODD, 32'h0);
    chk(rd, L1 | 32'h1);
    core_u.issue(1'b0, 1'b0);
    wait_evt(3'b100);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // Duplicate check off: random write by command commits despite a match
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b1, `OFS_CMD, 32'h2);
    wait_evt(3'b001);
    tally_and_finish;
  end
endmodule
bind tlb_entry_write tlb_entry_write_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tlb_write_indexed_op(tlb_write_indexed_op),
  .tlb_write_random_op(tlb_write_random_op), .cp0_usable(cp0_usable), .tlb_write_busy(tlb_write_busy),
  .tlb_write_done(tlb_write_done), .machine_check(machine_check), .cop_unusable(cop_unusable), .irq(irq));
